// file: hdl/bldc_commutation_zcp_blanking.sv
// Commutation steering and zero-crossing blanking top level.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "bldc_cfg.svh"
// How it works
// - Six gate pins, pairs per phase A-B-C.
// - Gate pins always driven both levels.
// - One skip-mask write moves the PWM.
// - Pull-ups disabled on all digital pins.
// - Low duty: window blocks crossings while terminal conducts.
// - Window comes from the PWM timebase.
// - Low duty: observe inactive tail only.
// - High duty: tail plus whole active part.
// - Operand order follows falling or rising slope.
// - Blanking needs no per-period interrupt.
// - Six states pick open phase versus neutral.
module bldc_commutation_zcp_blanking #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  output logic phase_a_gate_enable,
  output logic phase_a_pwm_drive,
  output logic phase_b_gate_enable,
  output logic phase_b_pwm_drive,
  output logic phase_c_gate_enable,
  output logic phase_c_pwm_drive,
  output logic [5:0] gateOe,
  output logic pullupEnable,
  output logic tracking_window_output,
  input wire logic phase_a_feedback,
  input wire logic phase_b_feedback,
  input wire logic phase_c_feedback,
  input wire logic virtual_neutral_feedback
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctrl;
  logic [7:0] pin_skip_mask;
  logic [W-1:0] period;
  logic [W-1:0] duty;
  logic [W-1:0] window;
  logic [1:0] status;
  logic [1:0] mask;
  logic [5:0] gateLevel;
  logic [5:0] gateOut;
  logic cmpPrev;
  logic cmpPrevValid;
  logic zcpEvent;
  bldc_pkg::comm_state_t commState;
  pwm_if #(.W(W)) pw();
  pwm_track_gen #(.W(W)) gen (
    .clock(clock),
    .rst(rst),
    .pw(pw)
  );
  assign pw.period = period;
  assign pw.duty = duty;
  assign pw.window = window;
  assign pw.highDuty = ctrl[`CTRL_HIGHDUTY];
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire wrCtrl = wr && (addr == `REG_CTRL);
  wire wrSkip = wr && (addr == `REG_SKIP);
  wire wrPeriod = wr && (addr == `REG_PERIOD);
  wire wrDuty = wr && (addr == `REG_DUTY);
  wire wrWindow = wr && (addr == `REG_WINDOW);
  wire wrMask = wr && (addr == `REG_MASK);
  wire wrLevel = wr && (addr == `REG_LEVEL);
  wire rdStatus = rd && (addr == `REG_STATUS);
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr)
      `REG_CTRL: next_rdata = {24'h000000, ctrl};
      `REG_SKIP: next_rdata = {24'h000000, pin_skip_mask};
      `REG_PERIOD: next_rdata = {{(32-W){1'b0}}, period};
      `REG_DUTY: next_rdata = {{(32-W){1'b0}}, duty};
      `REG_WINDOW: next_rdata = {{(32-W){1'b0}}, window};
      `REG_STATUS: next_rdata = {30'h0, status};
      `REG_MASK: next_rdata = {30'h0, mask};
      `REG_LEVEL: next_rdata = {26'h0, gateLevel};
      default: next_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? next_rdata : 32'h0000_0000;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= 8'h00;
      pin_skip_mask <= `SKIP_RESET;
      period <= W'(`PERIOD_RESET);
      duty <= W'(`DUTY_RESET);
      window <= W'(`WINDOW_RESET);
      mask <= 2'h0;
      gateLevel <= 6'h00;
    end else begin
      if (wrCtrl) ctrl <= wdata[7:0];
      if (wrSkip) pin_skip_mask <= wdata[7:0];
      if (wrPeriod) period <= wdata[W-1:0];
      if (wrDuty) duty <= wdata[W-1:0];
      if (wrWindow) window <= wdata[W-1:0];
      if (wrMask) mask <= wdata[1:0];
      if (wrLevel) gateLevel <= wdata[5:0];
    end
  end
  // ----------------------------------------
  // Commutation state and comparator routing
  // ----------------------------------------
  function automatic bldc_pkg::comm_state_t decodeState(input logic [2:0] s);
    unique case (s)
      3'h0: decodeState = bldc_pkg::ST0;
      3'h1: decodeState = bldc_pkg::ST1;
      3'h2: decodeState = bldc_pkg::ST2;
      3'h3: decodeState = bldc_pkg::ST3;
      3'h4: decodeState = bldc_pkg::ST4;
      default: decodeState = bldc_pkg::ST5;
    endcase
  endfunction
  always_ff @(posedge clock) begin
    if (rst) begin
      commState <= bldc_pkg::ST0;
    end else if (wrCtrl) begin
      commState <= decodeState(wdata[`CTRL_STATE_LO+2:`CTRL_STATE_LO]);
    end
  end
  bldc_pkg::open_phase_t openPhase;
  always_comb begin
    openPhase = bldc_pkg::OPEN_C;
    unique case (commState)
      bldc_pkg::ST0, bldc_pkg::ST3: openPhase = bldc_pkg::OPEN_C;
      bldc_pkg::ST1, bldc_pkg::ST4: openPhase = bldc_pkg::OPEN_A;
      bldc_pkg::ST2, bldc_pkg::ST5: openPhase = bldc_pkg::OPEN_B;
    endcase
  end
  wire openFeedback = (openPhase == bldc_pkg::OPEN_A) ? phase_a_feedback :
                      (openPhase == bldc_pkg::OPEN_B) ? phase_b_feedback : phase_c_feedback;
  // Falling slope puts the phase on the plus side, rising puts the neutral there.
  wire cmpPlus = ctrl[`CTRL_FALLING] ? openFeedback : virtual_neutral_feedback;
  wire cmpMinus = ctrl[`CTRL_FALLING] ? virtual_neutral_feedback : openFeedback;
  wire cmpOut = cmpPlus && !cmpMinus;
  // ----------------------------------------
  // Blanked zero-crossing detection
  // ----------------------------------------
  // Outside the window the last sample is discarded, so a transition straddling a blanked interval
  // is never taken as a crossing; this trades a window-start latency of one cycle for immunity.
  always_ff @(posedge clock) begin
    if (rst) begin
      cmpPrev <= 1'b0;
      cmpPrevValid <= 1'b0;
    end else begin
      cmpPrev <= cmpOut;
      cmpPrevValid <= pw.track && ctrl[`CTRL_ENABLE];
    end
  end
  assign zcpEvent = pw.track && ctrl[`CTRL_ENABLE] && cmpPrevValid && cmpOut && !cmpPrev;
  // Set wins over the clearing read.
  always_ff @(posedge clock) begin
    if (rst) begin
      status <= 2'h0;
    end else begin
      status[`STAT_ZCP] <= zcpEvent || (status[`STAT_ZCP] && !rdStatus);
      status[`STAT_PERIOD] <= pw.wrap || (status[`STAT_PERIOD] && !rdStatus);
    end
  end
  assign irq = |(status & mask);
  // ----------------------------------------
  // Gate-drive steering
  // ----------------------------------------
  // Pin n of the port is skipped when its mask bit is one; unskipped PWM pins carry the motor PWM.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      gateOut[i] = pin_skip_mask[i+`PIN_OFFSET] ? gateLevel[i] : pw.motorPwm;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_a_gate_enable <= 1'b0;
      phase_a_pwm_drive <= 1'b0;
      phase_b_gate_enable <= 1'b0;
      phase_b_pwm_drive <= 1'b0;
      phase_c_gate_enable <= 1'b0;
      phase_c_pwm_drive <= 1'b0;
      tracking_window_output <= 1'b0;
    end else begin
      phase_a_gate_enable <= gateOut[0];
      phase_a_pwm_drive <= gateOut[1];
      phase_b_gate_enable <= gateOut[2];
      phase_b_pwm_drive <= gateOut[3];
      phase_c_gate_enable <= gateOut[4];
      phase_c_pwm_drive <= gateOut[5];
      tracking_window_output <= pw.track;
    end
  end
  assign gateOe = 6'h3F;
  assign pullupEnable = 1'b0;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_push_pull;
    @(posedge clock) disable iff (rst) gateOe == 6'h3F;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("Gate pin not driven.");
  property p_no_pullup;
    @(posedge clock) disable iff (rst) !pullupEnable;
  endproperty
  a_no_pullup: assert property (p_no_pullup) else $error("Pull-ups enabled.");
  property p_skip_route;
    @(posedge clock) disable iff (rst)
      (pin_skip_mask == 8'hDF && $stable(pin_skip_mask)) |=> (phase_b_pwm_drive == $past(pw.motorPwm));
  endproperty
  a_skip_route: assert property (p_skip_route) else $error("PWM not on the unskipped pin.");
  property p_pair_order;
    @(posedge clock) disable iff (rst)
      (pin_skip_mask == 8'hF7 && $stable(pin_skip_mask)) |=> (phase_a_pwm_drive == $past(pw.motorPwm));
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("Phase A PWM pin misplaced.");
  property p_blank;
    @(posedge clock) disable iff (rst) !pw.track |=> !status[`STAT_ZCP] || $past(status[`STAT_ZCP]);
  endproperty
  a_blank: assert property (p_blank) else $error("Crossing accepted outside window.");
  property p_flag_set;
    @(posedge clock) disable iff (rst) zcpEvent |=> status[`STAT_ZCP];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Crossing flag not set.");
  property p_track_out;
    @(posedge clock) disable iff (rst) pw.track |=> tracking_window_output;
  endproperty
  a_track_out: assert property (p_track_out) else $error("Window output lags.");
  property p_slope;
    @(posedge clock) disable iff (rst)
      (ctrl[`CTRL_FALLING] && openPhase == bldc_pkg::OPEN_A) |-> (cmpPlus == phase_a_feedback);
  endproperty
  a_slope: assert property (p_slope) else $error("Falling slope operands wrong.");
  property p_state_open;
    @(posedge clock) disable iff (rst) (commState == bldc_pkg::ST1) |-> (openPhase == bldc_pkg::OPEN_A);
  endproperty
  a_state_open: assert property (p_state_open) else $error("State 1 open phase wrong.");
  // ----------------------------------------
  // Routing and flag checks
  // ----------------------------------------
  // These watch the pins and the flag, so a broken decode shows up even when the bench misses it.
  property p_zcp_in_window;
    @(posedge clock) disable iff (rst) zcpEvent |-> (pw.track && $past(pw.track));
  endproperty
  a_zcp_in_window: assert property (p_zcp_in_window) else $error("Crossing taken at window edge.");
  property p_zcp_enabled;
    @(posedge clock) disable iff (rst) (!ctrl[`CTRL_ENABLE] || !$past(ctrl[`CTRL_ENABLE])) |-> !zcpEvent;
  endproperty
  a_zcp_enabled: assert property (p_zcp_enabled) else $error("Crossing taken while disabled.");
  property p_read_clear;
    @(posedge clock) disable iff (rst) (rdStatus && !zcpEvent) |=> !status[`STAT_ZCP];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Crossing flag survived its read.");
  property p_flag_sticky;
    @(posedge clock) disable iff (rst) (status[`STAT_ZCP] && !rdStatus) |=> status[`STAT_ZCP];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Crossing flag lost without a read.");
  property p_open_a;
    @(posedge clock) disable iff (rst)
      (commState == bldc_pkg::ST1 || commState == bldc_pkg::ST4) |-> (openFeedback == phase_a_feedback);
  endproperty
  a_open_a: assert property (p_open_a) else $error("Phase A not sensed in its states.");
  property p_open_b;
    @(posedge clock) disable iff (rst)
      (commState == bldc_pkg::ST2 || commState == bldc_pkg::ST5) |-> (openFeedback == phase_b_feedback);
  endproperty
  a_open_b: assert property (p_open_b) else $error("Phase B not sensed in its states.");
  property p_open_c;
    @(posedge clock) disable iff (rst)
      (commState == bldc_pkg::ST0 || commState == bldc_pkg::ST3) |-> (openFeedback == phase_c_feedback);
  endproperty
  a_open_c: assert property (p_open_c) else $error("Phase C not sensed in its states.");
  property p_rising_operands;
    @(posedge clock) disable iff (rst)
      !ctrl[`CTRL_FALLING] |-> (cmpPlus == virtual_neutral_feedback && cmpMinus == openFeedback);
  endproperty
  a_rising_operands: assert property (p_rising_operands) else $error("Rising slope operands wrong.");
  property p_a_level;
    @(posedge clock) disable iff (rst) pin_skip_mask[`PIN_OFFSET] |=> (phase_a_gate_enable == $past(gateLevel[0]));
  endproperty
  a_a_level: assert property (p_a_level) else $error("Phase A enable pin misplaced.");
  property p_b_level;
    @(posedge clock) disable iff (rst) pin_skip_mask[`PIN_OFFSET+2] |=> (phase_b_gate_enable == $past(gateLevel[2]));
  endproperty
  a_b_level: assert property (p_b_level) else $error("Phase B enable pin misplaced.");
  property p_c_level;
    @(posedge clock) disable iff (rst) pin_skip_mask[`PIN_OFFSET+4] |=> (phase_c_gate_enable == $past(gateLevel[4]));
  endproperty
  a_c_level: assert property (p_c_level) else $error("Phase C enable pin misplaced.");
  property p_pwm_a_route;
    @(posedge clock) disable iff (rst) !pin_skip_mask[`PIN_OFFSET+1] |=> (phase_a_pwm_drive == $past(pw.motorPwm));
  endproperty
  a_pwm_a_route: assert property (p_pwm_a_route) else $error("Unskipped phase A pin lacks PWM.");
  property p_wrap_flag;
    @(posedge clock) disable iff (rst) pw.wrap |=> status[`STAT_PERIOD];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("Period flag not set at wrap.");
endmodule

// file: shared/bldc_cfg.svh
// Offsets, field positions, reset values and timing counts for the commutation block.
`ifndef BLDC_CFG_SVH
`define BLDC_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_SKIP 8'h04
`define REG_PERIOD 8'h08
`define REG_DUTY 8'h0C
`define REG_WINDOW 8'h10
`define REG_STATUS 8'h14
`define REG_MASK 8'h18
`define REG_LEVEL 8'h1C
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_ENABLE 0
`define CTRL_FALLING 1
`define CTRL_HIGHDUTY 2
`define CTRL_STATE_LO 4
`define STAT_ZCP 0
`define STAT_PERIOD 1
`define SKIP_RESET 8'hFF
`define PERIOD_RESET 16'h28B0
`define DUTY_RESET 16'h0000
`define WINDOW_RESET 16'h0400
`define PIN_OFFSET 2
`endif

// file: shared/bldc_pkg.sv
// Types shared by the commutation block.
package bldc_pkg;
  typedef enum logic [5:0] {
    ST0 = 6'h01,
    ST1 = 6'h02,
    ST2 = 6'h04,
    ST3 = 6'h08,
    ST4 = 6'h10,
    ST5 = 6'h20
  } comm_state_t;
  typedef enum logic [1:0] {
    OPEN_A = 2'h0,
    OPEN_B = 2'h1,
    OPEN_C = 2'h2
  } open_phase_t;
endpackage

// file: shared/pwm_if.sv
// Timebase signals shared between the top and the tracking generator.
`timescale 1ns/1ps
interface pwm_if #(parameter int W = 16);
  logic [W-1:0] period;
  logic [W-1:0] duty;
  logic [W-1:0] window;
  logic highDuty;
  logic motorPwm;
  logic track;
  logic wrap;
  modport gen(input period, input duty, input window, input highDuty, output motorPwm, output track, output wrap);
  modport use_(output period, output duty, output window, output highDuty, input motorPwm, input track, input wrap);
endinterface

// file: hdl/pwm_track_gen.sv
// PWM timebase with the synchronous tracking window.
`timescale 1ns/1ps
`include "bldc_cfg.svh"
module pwm_track_gen #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic rst,
  pwm_if.gen pw
);
  logic [W-1:0] count;
  logic pwmReg;
  logic trackReg;
  logic wrapReg;
  wire endCount = (count >= pw.period);
  wire activeNow = (count < pw.duty);
  wire tailNow = (count >= pw.period - pw.window) && !activeNow;
  wire next_track = tailNow || (pw.highDuty && activeNow);
  // One counter drives both the motor PWM and the window, so they never drift apart.
  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
      pwmReg <= 1'b0;
      trackReg <= 1'b0;
      wrapReg <= 1'b0;
    end else begin
      count <= endCount ? '0 : count + 1'b1;
      pwmReg <= activeNow;
      trackReg <= next_track;
      wrapReg <= endCount;
    end
  end
  assign pw.motorPwm = pwmReg;
  assign pw.track = trackReg;
  assign pw.wrap = wrapReg;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_low_duty_window;
    @(posedge clock) disable iff (rst) (!pw.highDuty && $past(!pw.highDuty) && pw.track) |-> !pw.motorPwm;
  endproperty
  a_low_duty_window: assert property (p_low_duty_window) else $error("Window open during active time at low duty.");
  property p_high_duty_window;
    @(posedge clock) disable iff (rst)
      ($stable(pw.highDuty) && pw.highDuty && $stable(pw.duty) && pw.motorPwm && $past(pw.motorPwm)) |-> pw.track;
  endproperty
  a_high_duty_window: assert property (p_high_duty_window) else $error("Window closed during active time at high duty.");
  property p_sync_start;
    @(posedge clock) disable iff (rst) (pw.wrap && pw.duty != 0 && $stable(pw.duty)) |=> pw.motorPwm;
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("PWM not started at period wrap.");
endmodule

// file: sim/bldc_feedback_model.sv
// Far-side model of the attenuated phase and neutral feedback.
`timescale 1ns/1ps
module bldc_feedback_model (
  input wire logic clock,
  input wire logic [2:0] emf,
  input wire logic neutral,
  input wire logic noisy,
  input wire logic pwmOn,
  output logic phase_a_feedback,
  output logic phase_b_feedback,
  output logic phase_c_feedback,
  output logic virtual_neutral_feedback
);
  logic toggle = 1'b0;
  // ----------------------------------------
  // Terminal levels
  // ----------------------------------------
  // While the driven phase conducts, the terminals are clamped by body diodes and carry no crossing information.
  // The noise flips every cycle so that the blanking has real comparator edges to reject.
  // The neutral stays clean, because a shared flip would cancel in the comparison.
  always @(posedge clock) begin
    toggle <= ~toggle;
    {phase_c_feedback, phase_b_feedback, phase_a_feedback} <= emf ^ {3{noisy & pwmOn & toggle}};
    virtual_neutral_feedback <= neutral;
  end
endmodule

// file: sim/tb.sv
// Self-checking bench for commutation steering and crossing blanking.
`timescale 1ns/1ps
`include "bldc_cfg.svh"
module tb;
  logic clock;
  logic rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic irq;
  logic [5:0] gates;
  logic [5:0] gateOe;
  logic pullupEnable;
  logic windowOut;
  logic [3:0] fb;
  logic [2:0] emf;
  logic neutral;
  logic noisy;
  logic [31:0] got;
  int highs [0:6];
  int fails;
  int nTests;
  bldc_commutation_zcp_blanking #(.W(16)) dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .phase_a_gate_enable(gates[0]), .phase_a_pwm_drive(gates[1]),
    .phase_b_gate_enable(gates[2]), .phase_b_pwm_drive(gates[3]), .phase_c_gate_enable(gates[4]),
    .phase_c_pwm_drive(gates[5]), .gateOe(gateOe), .pullupEnable(pullupEnable),
    .tracking_window_output(windowOut), .phase_a_feedback(fb[0]), .phase_b_feedback(fb[1]),
    .phase_c_feedback(fb[2]), .virtual_neutral_feedback(fb[3]));
  bldc_feedback_model far (.clock(clock), .emf(emf), .neutral(neutral), .noisy(noisy),
    .pwmOn(gates[1] | gates[3] | gates[5]), .phase_a_feedback(fb[0]), .phase_b_feedback(fb[1]),
    .phase_c_feedback(fb[2]), .virtual_neutral_feedback(fb[3]));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("fails=%0d checks=%0d", fails, nTests);
    if (fails == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic regRead(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  // Counts high cycles of each gate and of the window over one period of 21 cycles.
  task automatic countHighs();
    for (int i = 0; i < 7; i++) highs[i] = 0;
    repeat (21) begin
      @(posedge clock);
      for (int i = 0; i < 6; i++) highs[i] += (gates[i] === 1'b1) ? 1 : 0;
      highs[6] += (windowOut === 1'b1) ? 1 : 0;
    end
  endtask
  // A crossing outside the window is lost, so the flip waits for a fresh window and lands near its start.
  // Taking a window that is already open could put the flip on its closing edge; the wait is bounded.
  task automatic waitWindow();
    int n;
    n = 0;
    while (windowOut !== 1'b0 && n <= 60) begin
      @(posedge clock);
      n++;
    end
    while (windowOut !== 1'b1 && n <= 60) begin
      @(posedge clock);
      n++;
    end
    if (n > 60) begin
      chk(32'h0, 32'h1);
      conclude();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic resetValues();
    chk({26'h0, gates}, 32'h0);
    chk({26'h0, gateOe}, 32'h3F);
    chk({31'h0, pullupEnable}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    regRead(`REG_SKIP);
    chk(got, 32'h000000FF);
    regRead(`REG_PERIOD);
    chk(got, 32'h000028B0);
    regRead(`REG_WINDOW);
    chk(got, 32'h00000400);
    regWrite(8'h20, 32'hFFFFFFFF);
    regRead(8'h20);
    chk(got, 32'h0);
  endtask
  task automatic steering();
    int e1 [0:5] = '{21, 4, 21, 0, 21, 0};
    int e2 [0:5] = '{21, 0, 21, 4, 21, 0};
    regWrite(`REG_PERIOD, 32'h14);
    regWrite(`REG_DUTY, 32'h4);
    regWrite(`REG_WINDOW, 32'hA);
    regWrite(`REG_LEVEL, 32'h15);
    regWrite(`REG_SKIP, 32'hF7);
    regWrite(`REG_CTRL, 32'h1);
    repeat (25) @(posedge clock);
    countHighs();
    for (int i = 0; i < 6; i++) chk(highs[i], e1[i]);
    chk(highs[6], 32'hB);
    regWrite(`REG_SKIP, 32'hDF);
    repeat (3) @(posedge clock);
    countHighs();
    for (int i = 0; i < 6; i++) chk(highs[i], e2[i]);
    #1;
    chk({31'h0, irq}, 32'h0);
    regWrite(`REG_MASK, 32'h2);
    #1;
    chk({31'h0, irq}, 32'h1);
    regRead(`REG_STATUS);
    chk(got & 32'h2, 32'h2);
    regWrite(`REG_CTRL, 32'h5);
    repeat (3) @(posedge clock);
    countHighs();
    chk(highs[6], 32'hF);
  endtask
  // Odd states watch a rising slope, even states a falling one; the other phases hold still.
  task automatic crossing(input logic [2:0] s);
    logic fall;
    int op;
    fall = ~s[0];
    op = (s % 3 == 0) ? 2 : ((s % 3 == 1) ? 0 : 1);
    neutral <= ~fall;
    emf <= fall ? 3'h0 : 3'h7;
    noisy <= 1'b1;
    regWrite(`REG_CTRL, {25'h0, s, 2'h0, fall, 1'b1});
    repeat (42) @(posedge clock);
    regRead(`REG_STATUS);
    repeat (42) @(posedge clock);
    regRead(`REG_STATUS);
    chk(got & 32'h1, 32'h0);
    waitWindow();
    emf <= emf ^ 3'(1 << op);
    repeat (25) @(posedge clock);
    #1;
    chk({31'h0, irq}, 32'h1);
    regRead(`REG_STATUS);
    chk(got & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
  endtask
  // A reset in mid-run must bring the pins and registers back to their reset values.
  task automatic midReset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    chk({26'h0, gates}, 32'h0);
    chk({31'h0, windowOut}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    regRead(`REG_SKIP);
    chk(got, 32'h000000FF);
    regRead(`REG_MASK);
    chk(got, 32'h0);
    regRead(`REG_CTRL);
    chk(got, 32'h0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    emf = 3'h0;
    neutral = 1'b0;
    noisy = 1'b0;
    fails = 0;
    nTests = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    resetValues();
    steering();
    regWrite(`REG_MASK, 32'h1);
    for (int s = 0; s < 6; s++) crossing(3'(s));
    midReset();
    conclude();
  end
endmodule
